// File: inc/rmb_pkg.sv
// Shared constants and carriers of the custom B reference monitor registers.
// Assumes: one 125 MHz clock, AHB-Lite word access, 8-bit register fields.

package rmb_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int RMB_REG_W  = 8;     // Width of every register field
    localparam int RMB_IDX_W  = 8;     // Register index width
    localparam int RMB_ADDR_W = 10;    // Decoded byte address bits
    localparam int RMB_THR_W  = 16;    // Coarse threshold width
    localparam int RMB_MULT_W = 14;    // Frequency multiple width

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] RMB_IDX_MULT_LO   = 8'h71; // Multiple bits 7:0
    localparam logic [7:0] RMB_IDX_MULT_HI   = 8'h72; // Multiple bits 13:8
    localparam logic [7:0] RMB_IDX_SCM_LOW   = 8'h73; // Single-cycle low
    localparam logic [7:0] RMB_IDX_SCM_HIGH  = 8'h74; // Single-cycle high
    localparam logic [7:0] RMB_IDX_CFM_LO_LO = 8'h75; // Coarse low, lsb
    localparam logic [7:0] RMB_IDX_CFM_LO_HI = 8'h76; // Coarse low, msb
    localparam logic [7:0] RMB_IDX_CFM_HI_LO = 8'h77; // Coarse high, lsb
    localparam logic [7:0] RMB_IDX_CFM_HI_HI = 8'h78; // Coarse high, msb
    localparam logic [7:0] RMB_IDX_WINDOW    = 8'h79; // Window cycles - 1
    localparam logic [7:0] RMB_IDX_PREDIV    = 8'h7a; // Predivide control
    localparam logic [7:0] RMB_IDX_STATUS    = 8'h80; // Monitor status

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         RMB_PREDIV_BIT = 0;     // Predivide enable bit
    localparam int         RMB_STAT_SCM   = 0;     // Single-cycle fail bit
    localparam int         RMB_STAT_CFM   = 1;     // Coarse fail bit
    localparam int         RMB_STAT_WIN   = 2;     // Window running bit
    localparam int         RMB_MULT_HI_W  = 6;     // Used bits of mult hi
    localparam logic [7:0] RMB_REG_RST    = 8'h00; // Reset of every field

    // ------------------------------------------------------------------
    // Predivider and bus codes
    // ------------------------------------------------------------------
    localparam logic [1:0] RMB_PREDIV_LAST = 2'h3; // Divide by four
    localparam logic [1:0] RMB_HTRANS_NSEQ = 2'h2; // NONSEQ transfer
    localparam logic [2:0] RMB_HSIZE_WORD  = 3'h2; // 32-bit transfer

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // Settings handed to the monitors
    typedef struct packed {
        logic [7:0]  scm_low;      // Single-cycle lower threshold
        logic [7:0]  scm_high;     // Single-cycle upper threshold
        logic [15:0] cfm_low;      // Coarse lower threshold
        logic [15:0] cfm_high;     // Coarse upper threshold
        logic [7:0]  window_m1;    // Window cycles minus one
        logic        predivide;    // Divide reference by four
        logic [13:0] freq_mult;    // Frequency as multiple of 8 kHz
    } rmb_cfg_s;

    // Measurements coming back from the monitors
    typedef struct packed {
        logic        scm_valid;    // Single-cycle value is new
        logic [7:0]  scm_value;    // Single-cycle measured value
        logic        cfm_valid;    // Coarse value is new
        logic [15:0] cfm_value;    // Coarse measured value
    } rmb_meas_s;

endpackage : rmb_pkg

// File: logic/rmb_window.sv
// Reference predivider and sample window counter for custom B.
// Assumes: ref_tick is a one-cycle pulse per reference edge, clk-synchronous.
`timescale 1ns/1ps

module rmb_window (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ref_tick,
    input  wire logic       predivide,
    input  wire logic [7:0] window_m1,
    output logic            meas_tick,
    output logic            window_done,
    output logic            window_busy
);
    import rmb_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] div_cnt;   // Reference edges seen within a quartet
        logic [7:0] win_cnt;   // Measured ticks in the current window
        logic       tick;      // Registered measurement tick
        logic       done;      // Registered end-of-window pulse
        logic       busy;      // Window holds at least one tick
    } rmb_win_s;

    rmb_win_s st_r;            // Registered state
    rmb_win_s st_nxt;          // Next state

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Predivide then count ticks until the programmed window closes
    always_comb begin
        logic tick_now;        // Tick after optional divide
        tick_now = 1'b0;
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        st_nxt.done = 1'b0;
        if (ref_tick) begin
            if (predivide) begin
                // Pass only every fourth reference edge
                st_nxt.div_cnt = st_r.div_cnt + 2'h1;
                tick_now = (st_r.div_cnt == RMB_PREDIV_LAST);
            end else begin
                // Undivided, every edge is a tick
                st_nxt.div_cnt = 2'h0;
                tick_now = 1'b1;
            end
        end
        if (tick_now) begin
            st_nxt.tick = 1'b1;
            if (st_r.win_cnt >= window_m1) begin
                // Window holds window_m1 + 1 ticks
                st_nxt.win_cnt = 8'h00;
                st_nxt.done = 1'b1;
                st_nxt.busy = 1'b0;
            end else begin
                // Still inside the window
                st_nxt.win_cnt = st_r.win_cnt + 8'h01;
                st_nxt.busy = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Whole state in one clocked process
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign meas_tick   = st_r.tick;
    assign window_done = st_r.done;
    assign window_busy = st_r.busy;

endmodule : rmb_window

// File: logic/rmb_regs.sv
// Custom B reference monitor settings: register bank on AHB-Lite,
// predivided window timing and threshold checks for both monitors.
// Assumes: single 125 MHz clock; monitors deliver measurements and
// reference edge pulses synchronous to clk; bus has this one slave.
`timescale 1ns/1ps

module rmb_regs (
    input  wire logic              clk,
    input  wire logic              reset_n,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Monitor side
    input  wire logic              ref_tick,
    input  wire rmb_pkg::rmb_meas_s meas,
    output rmb_pkg::rmb_cfg_s      cfg,
    output logic                   cfm_ref_tick,
    output logic                   cfm_window_done,
    output logic                   scm_fail,
    output logic                   cfm_fail
);
    import rmb_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_r;    // Two-stage release of reset_n
    logic       rst_n;         // Synchronised reset for the design

    // Assert at once, release after two edges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  scm_low;      // Single-cycle lower threshold
        logic [7:0]  scm_high;     // Single-cycle upper threshold
        logic [15:0] cfm_low;      // Coarse lower threshold
        logic [15:0] cfm_high;     // Coarse upper threshold
        logic [7:0]  window_m1;    // Window cycles minus one
        logic        predivide;    // Predivide enable
        logic [13:0] freq_mult;    // Frequency multiple of 8 kHz
        logic        wr_pend;      // Write data phase follows
        logic [7:0]  wr_idx;       // Index of the pending write
        logic [31:0] rdata;        // Registered read data
        logic        scm_fail;     // Single-cycle check failed
        logic        cfm_fail;     // Coarse check failed
    } rmb_regs_s;

    rmb_regs_s st_r;           // Registered state
    rmb_regs_s st_nxt;         // Next state

    // ------------------------------------------------------------------
    // Bus address phase
    // ------------------------------------------------------------------
    logic       take;          // Transfer accepted this edge
    logic       in_range;      // Upper address bits are zero
    logic [7:0] idx;           // Register index of the transfer
    logic       win_busy;      // Window counter has ticks pending

    assign in_range = (haddr[31:RMB_ADDR_W] == '0);
    assign idx      = haddr[RMB_ADDR_W-1:2];
    assign take     = hsel && hready && (htrans == RMB_HTRANS_NSEQ)
                      && (hsize == RMB_HSIZE_WORD);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Write data phase, read capture, and threshold checks
    always_comb begin
        logic [7:0] wb;        // Write byte from the data phase
        wb = hwdata[7:0];
        st_nxt = st_r;

        // Data phase of an earlier write stores the low byte
        if (st_r.wr_pend) begin
            if (st_r.wr_idx == RMB_IDX_SCM_LOW) begin
                st_nxt.scm_low = wb;
            end else if (st_r.wr_idx == RMB_IDX_SCM_HIGH) begin
                st_nxt.scm_high = wb;
            end else if (st_r.wr_idx == RMB_IDX_CFM_LO_LO) begin
                st_nxt.cfm_low[7:0] = wb;
            end else if (st_r.wr_idx == RMB_IDX_CFM_LO_HI) begin
                st_nxt.cfm_low[15:8] = wb;
            end else if (st_r.wr_idx == RMB_IDX_CFM_HI_LO) begin
                st_nxt.cfm_high[7:0] = wb;
            end else if (st_r.wr_idx == RMB_IDX_CFM_HI_HI) begin
                st_nxt.cfm_high[15:8] = wb;
            end else if (st_r.wr_idx == RMB_IDX_WINDOW) begin
                st_nxt.window_m1 = wb;
            end else if (st_r.wr_idx == RMB_IDX_PREDIV) begin
                // Only bit 0 is kept, the rest stay zero
                st_nxt.predivide = wb[RMB_PREDIV_BIT];
            end else if (st_r.wr_idx == RMB_IDX_MULT_LO) begin
                st_nxt.freq_mult[7:0] = wb;
            end else if (st_r.wr_idx == RMB_IDX_MULT_HI) begin
                // Six bits used, upper two stay zero
                st_nxt.freq_mult[13:8] = wb[RMB_MULT_HI_W-1:0];
            end else begin
                // Unmapped or read-only: ignored
                st_nxt.freq_mult = st_r.freq_mult;
            end
        end

        // New address phase
        st_nxt.wr_pend = take && hwrite && in_range;
        st_nxt.wr_idx  = idx;

        // Read data from the forwarded copy, so a read right after a
        // write to the same register sees the new value
        st_nxt.rdata = st_r.rdata;
        if (take && !hwrite) begin
            st_nxt.rdata = 32'h0000_0000;
            if (!in_range) begin
                // Outside the map reads zero
                st_nxt.rdata = 32'h0000_0000;
            end else if (idx == RMB_IDX_SCM_LOW) begin
                st_nxt.rdata[7:0] = st_nxt.scm_low;
            end else if (idx == RMB_IDX_SCM_HIGH) begin
                st_nxt.rdata[7:0] = st_nxt.scm_high;
            end else if (idx == RMB_IDX_CFM_LO_LO) begin
                st_nxt.rdata[7:0] = st_nxt.cfm_low[7:0];
            end else if (idx == RMB_IDX_CFM_LO_HI) begin
                st_nxt.rdata[7:0] = st_nxt.cfm_low[15:8];
            end else if (idx == RMB_IDX_CFM_HI_LO) begin
                st_nxt.rdata[7:0] = st_nxt.cfm_high[7:0];
            end else if (idx == RMB_IDX_CFM_HI_HI) begin
                st_nxt.rdata[7:0] = st_nxt.cfm_high[15:8];
            end else if (idx == RMB_IDX_WINDOW) begin
                st_nxt.rdata[7:0] = st_nxt.window_m1;
            end else if (idx == RMB_IDX_PREDIV) begin
                st_nxt.rdata[RMB_PREDIV_BIT] = st_nxt.predivide;
            end else if (idx == RMB_IDX_MULT_LO) begin
                st_nxt.rdata[7:0] = st_nxt.freq_mult[7:0];
            end else if (idx == RMB_IDX_MULT_HI) begin
                st_nxt.rdata[RMB_MULT_HI_W-1:0] =
                    st_nxt.freq_mult[13:8];
            end else if (idx == RMB_IDX_STATUS) begin
                // Live monitor state
                st_nxt.rdata[RMB_STAT_SCM] = st_r.scm_fail;
                st_nxt.rdata[RMB_STAT_CFM] = st_r.cfm_fail;
                st_nxt.rdata[RMB_STAT_WIN] = win_busy;
            end else begin
                // Unmapped index reads zero
                st_nxt.rdata = 32'h0000_0000;
            end
        end

        // Single-cycle check against the stored range
        if (meas.scm_valid) begin
            st_nxt.scm_fail = (meas.scm_value < st_r.scm_low)
                           || (meas.scm_value > st_r.scm_high);
        end

        // Coarse check against the 16-bit range
        if (meas.cfm_valid) begin
            st_nxt.cfm_fail = (meas.cfm_value < st_r.cfm_low)
                           || (meas.cfm_value > st_r.cfm_high);
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Every field returns to zero at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Window timing
    // ------------------------------------------------------------------
    // Predivides reference edges and marks each sample window
    rmb_window u_window (
        .clk         (clk),
        .rst_n       (rst_n),
        .ref_tick    (ref_tick),
        .predivide   (st_r.predivide),
        .window_m1   (st_r.window_m1),
        .meas_tick   (cfm_ref_tick),
        .window_done (cfm_window_done),
        .window_busy (win_busy)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Settings go straight from the register flops
    always_comb begin
        cfg.scm_low   = st_r.scm_low;
        cfg.scm_high  = st_r.scm_high;
        cfg.cfm_low   = st_r.cfm_low;
        cfg.cfm_high  = st_r.cfm_high;
        cfg.window_m1 = st_r.window_m1;
        cfg.predivide = st_r.predivide;
        cfg.freq_mult = st_r.freq_mult;
    end

    // Zero-wait slave, always OKAY
    assign hrdata    = st_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign scm_fail  = st_r.scm_fail;
    assign cfm_fail  = st_r.cfm_fail;

endmodule : rmb_regs

// File: test/rmb_regs_props.sv
// Concurrent checks on the ports of the custom B monitor register bank.
// Assumes: bound to rmb_regs; one clock, reset_n active low.
`timescale 1ns/1ps

module rmb_regs_props
    import rmb_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [2:0]        hsize,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              ref_tick,
    input wire rmb_pkg::rmb_meas_s meas,
    input wire rmb_pkg::rmb_cfg_s  cfg,
    input wire logic              cfm_ref_tick,
    input wire logic              cfm_window_done,
    input wire logic              scm_fail,
    input wire logic              cfm_fail
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [1:0] div_cnt_r; // Reference ticks seen while dividing
    logic [7:0] win_cnt_r; // Passed ticks in the open window
    logic       scm_out;   // Single-cycle value outside limits
    logic       cfm_out;   // Coarse value outside limits
    logic       div_hit;   // This reference tick is a fourth one

    assign scm_out = meas.scm_value < cfg.scm_low
                     || meas.scm_value > cfg.scm_high;
    assign cfm_out = meas.cfm_value < cfg.cfm_low
                     || meas.cfm_value > cfg.cfm_high;
    assign div_hit = ref_tick && div_cnt_r == 2'h3;

    // Track divider phase and window fill
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt_r <= 2'h0;
            win_cnt_r <= 8'h00;
        end else begin
            // Divider phase only moves on a reference tick
            if (ref_tick) begin
                div_cnt_r <= cfg.predivide ? div_cnt_r + 2'h1 : 2'h0;
            end
            if (cfm_window_done) begin
                win_cnt_r <= 8'h00;
            end else begin
                win_cnt_r <= win_cnt_r + 8'(cfm_ref_tick);
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------------
    // Bus access sequences
    // ------------------------------------------------------------------
    sequence s_acc(idx, wr);
        hsel && hready && htrans == RMB_HTRANS_NSEQ && hsize == RMB_HSIZE_WORD
        && hwrite == wr && haddr == {22'h0, idx, 2'b00};
    endsequence
    property p_wr(idx, fld, msk);
        s_acc(idx, 1'b1) ##1 1'b1 |=> fld == ($past(hwdata[7:0]) & msk);
    endproperty

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_wr_scm_low: assert property (
        p_wr(RMB_IDX_SCM_LOW, cfg.scm_low, 8'hff))
        else $error("single-cycle low limit not stored");
    chk_wr_cfm_low: assert property (
        p_wr(RMB_IDX_CFM_LO_HI, cfg.cfm_low[15:8], 8'hff))
        else $error("coarse low limit upper byte not stored");
    chk_wr_mult_hi: assert property (
        p_wr(RMB_IDX_MULT_HI, {2'b00, cfg.freq_mult[13:8]}, 8'h3f))
        else $error("frequency multiple upper bits not stored");
    chk_rd_prediv: assert property (
        s_acc(RMB_IDX_PREDIV, 1'b0) |=> hrdata == {31'h0, cfg.predivide})
        else $error("predivide read back wrong");
    chk_scm_eval: assert property (
        meas.scm_valid |=> scm_fail == $past(scm_out))
        else $error("single-cycle fail flag wrong");
    chk_cfm_eval: assert property (
        meas.cfm_valid |=> cfm_fail == $past(cfm_out))
        else $error("coarse fail flag wrong");
    chk_scm_hold: assert property (
        !meas.scm_valid |=> $stable(scm_fail))
        else $error("single-cycle fail flag moved without a value");
    chk_tick_plain: assert property (
        !cfg.predivide |=> cfm_ref_tick == $past(ref_tick))
        else $error("undivided tick not passed");
    chk_tick_div: assert property (
        cfg.predivide |=> cfm_ref_tick == $past(div_hit))
        else $error("divided tick not every fourth");
    chk_window_len: assert property (
        cfm_ref_tick |-> cfm_window_done == (win_cnt_r >= cfg.window_m1))
        else $error("window closed at wrong tick");
endmodule : rmb_regs_props

bind rmb_regs rmb_regs_props i_rmb_regs_props (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .ref_tick(ref_tick), .meas(meas),
    .cfg(cfg), .cfm_ref_tick(cfm_ref_tick),
    .cfm_window_done(cfm_window_done), .scm_fail(scm_fail),
    .cfm_fail(cfm_fail)
);

// File: test/testbench.sv
// Self-checking bench for the custom B monitor register bank.
// Assumes: rmb_regs is the only AHB-Lite slave; hready follows hreadyout.
`timescale 1ns/1ps

module testbench;
    import rmb_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk, reset_n, hsel, hwrite, ref_tick;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, cfm_ref_tick, cfm_window_done;
    logic        scm_fail, cfm_fail;
    rmb_meas_s   meas;
    rmb_cfg_s    cfg;
    int          errors, total_checks, n_tick, n_done;
    logic [15:0] pv [6] = '{16'h1233, 16'h1234, 16'h1240, 16'h1241,
                            16'h1300, 16'h1301};
    logic [5:0]  ps = 6'b111001; // Expected single-cycle fails
    logic [5:0]  pc = 6'b100001; // Expected coarse fails
    int          wt [3][5] = '{'{2, 0, 6, 6, 2}, '{0, 0, 3, 3, 3},
                               '{1, 1, 16, 4, 2}};

    rmb_regs i_rmb_regs (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ref_tick(ref_tick), .meas(meas), .cfg(cfg),
        .cfm_ref_tick(cfm_ref_tick), .cfm_window_done(cfm_window_done),
        .scm_fail(scm_fail), .cfm_fail(cfm_fail)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Count monitor pulses
    always @(posedge clk) begin
        if (cfm_ref_tick === 1'b1) n_tick++;
        if (cfm_window_done === 1'b1) n_done++;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One single word transfer, waits on hready in both phases
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= RMB_HTRANS_NSEQ;
        hsize  <= RMB_HSIZE_WORD;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : xfer

    task automatic wrt(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] unused_rd;
        xfer(1'b1, idx, d, unused_rd);
    endtask : wrt

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] got;
        xfer(1'b0, idx, 32'h0, got);
        chk(got, exp);
    endtask : rdc

    // One measurement pulse on both monitors
    task automatic probe(input logic [15:0] v);
        meas <= '{1'b1, v[7:0], 1'b1, v};
        @(posedge clk);
        meas <= '0;
        @(posedge clk);
    endtask : probe

    function automatic logic [15:0] h16(input logic [7:0] idx);
        return {idx + 8'h01, idx} ^ 16'hc3c3;
    endfunction : h16

    function automatic logic [7:0] msk(input logic [7:0] idx);
        if (idx == RMB_IDX_MULT_HI) return 8'h3f;
        if (idx == RMB_IDX_PREDIV) return 8'h01;
        return 8'hff;
    endfunction : msk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        {hsel, hwrite, ref_tick, haddr, hwdata, htrans, hsize} = '0;
        meas = '0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = RMB_IDX_MULT_LO; i <= RMB_IDX_PREDIV; i++) begin
            rdc(8'(i), 32'h0);
        end
        $display("test reset_values done");
        for (int i = RMB_IDX_MULT_LO; i <= RMB_IDX_PREDIV; i++) begin
            wrt(8'(i), {24'ha5a5a5, 8'(i) ^ 8'hc3});
            rdc(8'(i), {24'h0, (8'(i) ^ 8'hc3) & msk(8'(i))});
        end
        wrt(8'h7b, 32'hff);
        rdc(8'h7b, 32'h0);
        chk(cfg.scm_low, RMB_IDX_SCM_LOW ^ 8'hc3);
        chk(cfg.scm_high, RMB_IDX_SCM_HIGH ^ 8'hc3);
        chk(cfg.cfm_low, h16(RMB_IDX_CFM_LO_LO));
        chk(cfg.cfm_high, h16(RMB_IDX_CFM_HI_LO));
        chk(cfg.window_m1, RMB_IDX_WINDOW ^ 8'hc3);
        chk(cfg.predivide, (RMB_IDX_PREDIV ^ 8'hc3) & 8'h01);
        chk(cfg.freq_mult, h16(RMB_IDX_MULT_LO) & 16'h3fff);
        $display("test read_write done");
        wrt(RMB_IDX_SCM_LOW, 32'h34);
        wrt(RMB_IDX_SCM_HIGH, 32'h40);
        wrt(RMB_IDX_CFM_LO_LO, 32'h34);
        wrt(RMB_IDX_CFM_LO_HI, 32'h12);
        wrt(RMB_IDX_CFM_HI_LO, 32'h00);
        wrt(RMB_IDX_CFM_HI_HI, 32'h13);
        foreach (pv[k]) begin
            probe(pv[k]);
            chk(scm_fail, ps[k]);
            chk(cfm_fail, pc[k]);
        end
        $display("test limits done");
        // Last row divides, as software would for a fast reference
        foreach (wt[k]) begin
            int t0;
            int d0;
            wrt(RMB_IDX_WINDOW, wt[k][0]);
            wrt(RMB_IDX_PREDIV, wt[k][1]);
            t0 = n_tick;
            d0 = n_done;
            repeat (wt[k][2]) begin
                ref_tick <= 1'b1;
                @(posedge clk);
                ref_tick <= 1'b0;
                @(posedge clk);
            end
            repeat (3) @(posedge clk);
            chk(n_tick - t0, wt[k][3]);
            chk(n_done - d0, wt[k][4]);
        end
        $display("test window done");
        // Half-open window shows busy beside both fail flags
        wrt(RMB_IDX_PREDIV, 32'h0);
        ref_tick <= 1'b1;
        @(posedge clk);
        ref_tick <= 1'b0;
        @(posedge clk);
        rdc(RMB_IDX_STATUS, 32'h7);
        // Mid-run reset clears settings and flags
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(scm_fail, 1'b0);
        chk(cfm_fail, 1'b0);
        chk(cfg.cfm_low, 16'h0);
        rdc(RMB_IDX_SCM_HIGH, 32'h0);
        rdc(RMB_IDX_STATUS, 32'h0);
        $display("test reset_mid done");
        end_sim();
    end
endmodule : testbench
